// file: hw/sgcr_pkg.sv
// sgcr_pkg: constants and types of the switch global control register bank
// assumes: one 25 MHz core clock, byte-wide management register port
package sgcr_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int SGCR_PORTS = 4;
    localparam logic [7:0] SGCR_ADDR_GC0 = 8'h02;
    localparam logic [7:0] SGCR_ADDR_GC1 = 8'h03;
    localparam int SGCR_GC0_BACKOFF = 7;
    localparam int SGCR_GC0_LPURGE = 5;
    localparam int SGCR_GC0_FPURGE = 4;
    localparam int SGCR_GC0_COMPL = 1;
    localparam int SGCR_GC0_LINKAGE = 0;
    localparam int SGCR_GC1_PASSALL = 7;
    localparam int SGCR_GC1_JUMBO = 6;
    localparam logic [7:0] SGCR_GC0_WR_MASK = 8'hB3;
    localparam logic [7:0] SGCR_GC0_RSVD_VAL = 8'h0C;
    localparam logic [7:0] SGCR_GC1_WR_MASK = 8'hC0;
    localparam logic [7:0] SGCR_REG_RST = 8'h00;

    // ----------------------------------------
    // frame filter constants
    // ----------------------------------------
    localparam logic [15:0] SGCR_PAUSE_TYPE = 16'h8808;
    localparam logic [47:0] SGCR_TEST_DA = 48'h0180C2000001;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam longint SGCR_CLK_HZ = 25000000;
    localparam longint SGCR_FAST_AGE_US = 800;
    localparam longint SGCR_NORMAL_AGE_S = 300;
    // fast cycle must end strictly under the limit, so one cycle is taken off
    localparam longint SGCR_FAST_AGE_CYC = SGCR_FAST_AGE_US * SGCR_CLK_HZ / 1000000 - 1;
    localparam longint SGCR_NORMAL_AGE_CYC = SGCR_NORMAL_AGE_S * SGCR_CLK_HZ;
    localparam int SGCR_CNT_W = 33;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        SGCR_AGE_NORMAL = 3'b001,
        SGCR_AGE_SWEEP = 3'b010,
        SGCR_AGE_FAST = 3'b100
    } sgcr_age_state_t;

    typedef struct packed {
        logic valid;
        logic [15:0] type_len;
        logic [47:0] dest;
        logic flow_ctrl;
    } sgcr_frame_t;

    typedef struct packed {
        logic valid;
        logic unicast;
        logic [SGCR_PORTS-1:0] ports;
    } sgcr_entry_t;

endpackage

// file: hw/sgcr_sync2.sv
// sgcr_sync2: two flip-flop synchroniser for pin levels
// assumes: inputs are slow levels, no pulse shorter than two clocks matters
`timescale 1ns/100ps
module sgcr_sync2 #(
    parameter int W = 4
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync_out;

    always_comb begin
        next_meta = async_in;
        next_sync_out = meta;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= next_meta;
            sync_out <= next_sync_out;
        end
    end
endmodule

// file: hw/sgcr_purge_match.sv
// sgcr_purge_match: decides whether an address table entry is removed by a purge
// assumes: a table walker presents one entry per cycle, result one cycle later
`timescale 1ns/100ps
module sgcr_purge_match
    import sgcr_pkg::*;
#(
    parameter int PORTS = SGCR_PORTS,
    parameter bit FIXED_TABLE = 1'b0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic enable,
    input sgcr_entry_t entry,
    input wire logic [PORTS-1:0] learn_off,
    output logic hit
);
    logic next_hit;
    logic port_off;

    always_comb begin
        port_off = |(entry.ports & learn_off);
        if (FIXED_TABLE) begin
            // single forwarding port, unicast, learning off on it
            next_hit = enable & entry.valid & entry.unicast & $onehot(entry.ports) & port_off;
        end else begin
            // any learned entry of a port with learning off goes
            next_hit = enable & entry.valid & port_off;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hit <= 1'b0;
        end else begin
            hit <= next_hit;
        end
    end

    property p_match;
        @(posedge ref_clk) disable iff (sys_rst)
        (enable && entry.valid && (entry.ports & learn_off) != '0
            && (!FIXED_TABLE || (entry.unicast && $onehot(entry.ports)))) |=> hit;
    endproperty
    a_match: assert property (p_match) else $error("purge entry not flagged");

    property p_no_match;
        @(posedge ref_clk) disable iff (sys_rst)
        (!enable || (entry.ports & learn_off) == '0) |=> !hit;
    endproperty
    a_no_match: assert property (p_no_match) else $error("entry flagged wrongly");
endmodule

// file: hw/sgcr_top.sv
// sgcr_top: global control registers zero and one of the four-port switch
// assumes: byte register port, one-cycle strobes, read data the cycle after
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module sgcr_top
    import sgcr_pkg::*;
#(
    parameter int PORTS = SGCR_PORTS,
    parameter int CNT_W = SGCR_CNT_W,
    parameter logic [CNT_W-1:0] FAST_AGE_CYC = CNT_W'(SGCR_FAST_AGE_CYC),
    parameter logic [CNT_W-1:0] NORMAL_AGE_CYC = CNT_W'(SGCR_NORMAL_AGE_CYC)
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [PORTS-1:0] link_up_pin,
    input wire logic [PORTS-1:0] learn_off,
    input sgcr_entry_t learned_entry,
    input sgcr_entry_t fixed_entry,
    input sgcr_frame_t rx_frame,
    output logic backoff_alt,
    output logic learned_table_purge,
    output logic fixed_table_purge,
    output logic learned_purge_hit,
    output logic fixed_purge_hit,
    output logic compliance_drop_mode,
    output logic frame_drop,
    output logic pass_all_frames,
    output logic jumbo_2kb_accept,
    output logic age_all_now,
    output logic fast_age_active,
    output logic age_tick
);

    // ----------------------------------------
    // register port
    // ----------------------------------------
    logic [7:0] gc0;
    logic [7:0] gc1;
    logic [7:0] next_gc0;
    logic [7:0] next_gc1;
    logic [7:0] next_reg_rdata;
    logic next_learned_purge;
    logic next_fixed_purge;
    logic wr_gc0;
    logic wr_gc1;

    always_comb begin
        wr_gc0 = reg_wr && (reg_addr == SGCR_ADDR_GC0);
        wr_gc1 = reg_wr && (reg_addr == SGCR_ADDR_GC1);
        next_gc0 = gc0;
        next_gc1 = gc1;
        // trigger bits fire for one cycle then drop
        next_learned_purge = gc0[SGCR_GC0_LPURGE];
        next_fixed_purge = gc0[SGCR_GC0_FPURGE];
        next_gc0[SGCR_GC0_LPURGE] = 1'b0;
        next_gc0[SGCR_GC0_FPURGE] = 1'b0;
        // a fresh write wins over the self-clear of the same cycle
        if (wr_gc0) begin
            next_gc0 = reg_wdata & SGCR_GC0_WR_MASK;
        end
        if (wr_gc1) begin
            next_gc1 = reg_wdata & SGCR_GC1_WR_MASK;
        end
        next_reg_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                SGCR_ADDR_GC0: next_reg_rdata = gc0 | SGCR_GC0_RSVD_VAL;
                SGCR_ADDR_GC1: next_reg_rdata = gc1;
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gc0 <= SGCR_REG_RST;
            gc1 <= SGCR_REG_RST;
            reg_rdata <= 8'h00;
            learned_table_purge <= 1'b0;
            fixed_table_purge <= 1'b0;
        end else begin
            gc0 <= next_gc0;
            gc1 <= next_gc1;
            reg_rdata <= next_reg_rdata;
            learned_table_purge <= next_learned_purge;
            fixed_table_purge <= next_fixed_purge;
        end
    end

    // ----------------------------------------
    // mode outputs
    // ----------------------------------------
    logic next_backoff_alt;
    logic next_compliance;
    logic next_pass_all;
    logic next_jumbo;

    always_comb begin
        next_backoff_alt = gc0[SGCR_GC0_BACKOFF];
        next_compliance = gc0[SGCR_GC0_COMPL];
        next_pass_all = gc1[SGCR_GC1_PASSALL];
        next_jumbo = gc1[SGCR_GC1_JUMBO];
    end

    // mode bits lag the register by one cycle so every output is a flop
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            backoff_alt <= 1'b0;
            compliance_drop_mode <= 1'b0;
            pass_all_frames <= 1'b0;
            jumbo_2kb_accept <= 1'b0;
        end else begin
            backoff_alt <= next_backoff_alt;
            compliance_drop_mode <= next_compliance;
            pass_all_frames <= next_pass_all;
            jumbo_2kb_accept <= next_jumbo;
        end
    end

    // ----------------------------------------
    // flow-control frame filter
    // ----------------------------------------
    logic next_frame_drop;

    always_comb begin
        if (gc0[SGCR_GC0_COMPL]) begin
            next_frame_drop = rx_frame.valid && ((rx_frame.type_len == SGCR_PAUSE_TYPE)
                || (rx_frame.dest == SGCR_TEST_DA));
        end else begin
            next_frame_drop = rx_frame.valid && rx_frame.flow_ctrl;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            frame_drop <= 1'b0;
        end else begin
            frame_drop <= next_frame_drop;
        end
    end

    // ----------------------------------------
    // purge qualifiers for the table walker
    // ----------------------------------------
    // the walker owns the tables; only the keep-or-remove verdict lives here
    sgcr_purge_match #(.PORTS(PORTS), .FIXED_TABLE(1'b0)) u_learned_match (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .enable(1'b1),
        .entry(learned_entry),
        .learn_off(learn_off),
        .hit(learned_purge_hit)
    );

    sgcr_purge_match #(.PORTS(PORTS), .FIXED_TABLE(1'b1)) u_fixed_match (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .enable(1'b1),
        .entry(fixed_entry),
        .learn_off(learn_off),
        .hit(fixed_purge_hit)
    );

    // ----------------------------------------
    // link-loss aging
    // ----------------------------------------
    logic [PORTS-1:0] link_up;
    logic [PORTS-1:0] link_prev;
    logic [PORTS-1:0] next_link_prev;
    logic link_lost;

    sgcr_sync2 #(.W(PORTS)) u_link_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(link_up_pin),
        .sync_out(link_up)
    );

    sgcr_age_state_t age_state;
    sgcr_age_state_t next_age_state;
    logic [CNT_W-1:0] age_cnt;
    logic [CNT_W-1:0] next_age_cnt;
    logic next_age_all;
    logic next_fast_active;
    logic next_age_tick;

    always_comb begin
        next_link_prev = link_up;
        link_lost = gc0[SGCR_GC0_LINKAGE] && ((link_prev & ~link_up) != '0);
        next_age_state = age_state;
        next_age_cnt = age_cnt + CNT_W'(1);
        next_age_all = 1'b0;
        next_fast_active = 1'b0;
        next_age_tick = 1'b0;
        unique case (age_state)
            SGCR_AGE_NORMAL: begin
                if (link_lost) begin
                    next_age_state = SGCR_AGE_SWEEP;
                    next_age_cnt = '0;
                end else if (age_cnt >= NORMAL_AGE_CYC - CNT_W'(1)) begin
                    next_age_tick = 1'b1;
                    next_age_cnt = '0;
                end
            end
            SGCR_AGE_SWEEP: begin
                // every learned address goes at once
                next_age_all = 1'b1;
                next_fast_active = 1'b1;
                next_age_state = SGCR_AGE_FAST;
                next_age_cnt = '0;
            end
            SGCR_AGE_FAST: begin
                next_fast_active = 1'b1;
                if (link_lost) begin
                    next_age_state = SGCR_AGE_SWEEP;
                    next_age_cnt = '0;
                end else if (age_cnt >= FAST_AGE_CYC - CNT_W'(2)) begin
                    // back to the slow period, counted afresh
                    next_age_state = SGCR_AGE_NORMAL;
                    next_fast_active = 1'b0;
                    next_age_cnt = '0;
                end
            end
            default: begin
                next_age_state = SGCR_AGE_NORMAL;
                next_age_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            link_prev <= '0;
            age_state <= SGCR_AGE_NORMAL;
            age_cnt <= '0;
            age_all_now <= 1'b0;
            fast_age_active <= 1'b0;
            age_tick <= 1'b0;
        end else begin
            link_prev <= next_link_prev;
            age_state <= next_age_state;
            age_cnt <= next_age_cnt;
            age_all_now <= next_age_all;
            fast_age_active <= next_fast_active;
            age_tick <= next_age_tick;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [CNT_W-1:0] fast_len;

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !fast_age_active) begin
            fast_len <= '0;
        end else begin
            fast_len <= fast_len + CNT_W'(1);
        end
    end

    property p_backoff;
        @(posedge ref_clk) disable iff (sys_rst)
        wr_gc0 |=> ##1 backoff_alt == $past(reg_wdata[SGCR_GC0_BACKOFF], 2);
    endproperty
    a_backoff: assert property (p_backoff) else $error("back-off mode not taken");

    property p_lpurge;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_gc0 && reg_wdata[SGCR_GC0_LPURGE]) |=> ##1 learned_table_purge;
    endproperty
    a_lpurge: assert property (p_lpurge) else $error("learned purge not started");

    property p_lpurge_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        (learned_table_purge && !$past(wr_gc0)) |-> !gc0[SGCR_GC0_LPURGE];
    endproperty
    a_lpurge_clear: assert property (p_lpurge_clear) else $error("purge bit stuck");

    property p_fpurge;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_gc0 && reg_wdata[SGCR_GC0_FPURGE]) |=> ##1 fixed_table_purge
            ##1 (!fixed_table_purge || $past(wr_gc0, 2));
    endproperty
    a_fpurge: assert property (p_fpurge) else $error("fixed purge not one pulse");

    property p_compl_drop;
        @(posedge ref_clk) disable iff (sys_rst)
        (gc0[SGCR_GC0_COMPL] && rx_frame.valid && rx_frame.type_len == SGCR_PAUSE_TYPE)
            |=> frame_drop;
    endproperty
    a_compl_drop: assert property (p_compl_drop) else $error("pause type not dropped");

    property p_normal_drop;
        @(posedge ref_clk) disable iff (sys_rst)
        (!gc0[SGCR_GC0_COMPL] && rx_frame.valid) |=> frame_drop == $past(rx_frame.flow_ctrl);
    endproperty
    a_normal_drop: assert property (p_normal_drop) else $error("wrong flow-control drop");

    property p_fast_len;
        @(posedge ref_clk) disable iff (sys_rst)
        fast_age_active |-> fast_len < FAST_AGE_CYC;
    endproperty
    a_fast_len: assert property (p_fast_len) else $error("fast aging too long");

    property p_loss_sweep;
        @(posedge ref_clk) disable iff (sys_rst)
        (link_lost && age_state == SGCR_AGE_NORMAL) |=> ##1 age_all_now && fast_age_active;
    endproperty
    a_loss_sweep: assert property (p_loss_sweep) else $error("no age-out on link loss");

    property p_back_normal;
        @(posedge ref_clk) disable iff (sys_rst)
        $fell(fast_age_active) |-> age_state == SGCR_AGE_NORMAL && age_cnt <= CNT_W'(1);
    endproperty
    a_back_normal: assert property (p_back_normal) else $error("slow aging not resumed");

    property p_gc1_modes;
        @(posedge ref_clk) disable iff (sys_rst)
        wr_gc1 |=> ##1 pass_all_frames == $past(reg_wdata[SGCR_GC1_PASSALL], 2)
            && jumbo_2kb_accept == $past(reg_wdata[SGCR_GC1_JUMBO], 2);
    endproperty
    a_gc1_modes: assert property (p_gc1_modes) else $error("control one modes wrong");

    property p_rsvd;
        @(posedge ref_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == SGCR_ADDR_GC0) |=> (reg_rdata & 8'h4C) == SGCR_GC0_RSVD_VAL;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not fixed");

endmodule

// file: test/tb_top.sv
// tb_top: self-checking bench for the switch global control register bank
// assumes: sgcr_pkg compiled first; aging counts shortened by parameter
`timescale 1ns/100ps
module tb_top;
    import sgcr_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int FAST = 20;
    localparam int NORM = 50;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] link_up_pin = 4'hF;
    logic [3:0] learn_off = 4'h0;
    sgcr_entry_t learned_entry = '0;
    sgcr_entry_t fixed_entry = '0;
    sgcr_frame_t rx_frame = '0;
    logic backoff_alt, learned_table_purge, fixed_table_purge, learned_purge_hit;
    logic fixed_purge_hit, compliance_drop_mode, frame_drop, pass_all_frames;
    logic jumbo_2kb_accept, age_all_now, fast_age_active, age_tick;
    int miscompares = 0;
    int checks = 0;
    integer seed = 32'h9042;
    int i, n;
    logic [7:0] w, d;
    logic [3:0] lo;
    logic el, ef, ed, seen;
    sgcr_entry_t le, fe;
    sgcr_frame_t fr;

    sgcr_top #(
        .FAST_AGE_CYC(SGCR_CNT_W'(FAST)),
        .NORMAL_AGE_CYC(SGCR_CNT_W'(NORM))
    ) i_sgcr_top (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .link_up_pin(link_up_pin), .learn_off(learn_off),
        .learned_entry(learned_entry), .fixed_entry(fixed_entry), .rx_frame(rx_frame),
        .backoff_alt(backoff_alt), .learned_table_purge(learned_table_purge),
        .fixed_table_purge(fixed_table_purge), .learned_purge_hit(learned_purge_hit),
        .fixed_purge_hit(fixed_purge_hit), .compliance_drop_mode(compliance_drop_mode),
        .frame_drop(frame_drop), .pass_all_frames(pass_all_frames),
        .jumbo_2kb_accept(jumbo_2kb_accept), .age_all_now(age_all_now),
        .fast_age_active(fast_age_active), .age_tick(age_tick)
    );

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // data taken in the one cycle it stands
    task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // self-clear bits are gone by the time a later read lands
    function automatic logic [7:0] gc0_exp(input logic [7:0] v);
        return (v & 8'h83) | 8'h0C;
    endfunction

    task automatic no_age(input int cyc);
        seen = 1'b0;
        repeat (cyc) begin
            @(posedge ref_clk);
            #1 seen = seen | age_all_now;
        end
    endtask

    task automatic close_out;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // generous: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        close_out();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // reset values, reserved bits, unmapped address
        #1 chk1(backoff_alt | compliance_drop_mode | pass_all_frames, 1'b0);
        reg_read(SGCR_ADDR_GC0, d);
        chk8(d, 8'h0C);
        @(posedge ref_clk);
        #1 chk8(reg_rdata, 8'h00);
        reg_write(8'h04, 8'hFF);
        reg_write(SGCR_ADDR_GC0, 8'h40);
        reg_read(SGCR_ADDR_GC0, d);
        chk8(d, 8'h0C);
        reg_read(SGCR_ADDR_GC1, d);
        chk8(d, 8'h00);
        reg_read(8'h04, d);
        chk8(d, 8'h00);
        $display("test reset_map done");

        // random writes, self-clearing triggers and mode outputs
        for (i = 0; i < 24; i++) begin
            w = (i == 0) ? 8'hFE : (i == 1) ? 8'h00 : (i == 2) ? 8'h30 : 8'($random(seed));
            if (i % 2 == 0) w[0] = 1'b0;
            reg_write(i[0] ? SGCR_ADDR_GC1 : SGCR_ADDR_GC0, w);
            @(posedge ref_clk);
            #1;
            if (!i[0]) begin
                chk1(learned_table_purge, w[5]);
                chk1(fixed_table_purge, w[4]);
                chk1(backoff_alt, w[7]);
                chk1(compliance_drop_mode, w[1]);
            end else begin
                chk1(pass_all_frames, w[7]);
                chk1(jumbo_2kb_accept, w[6]);
            end
            @(posedge ref_clk);
            #1 chk1(learned_table_purge | fixed_table_purge, 1'b0);
            reg_read(i[0] ? SGCR_ADDR_GC1 : SGCR_ADDR_GC0, d);
            chk8(d, i[0] ? (w & 8'hC0) : gc0_exp(w));
        end
        $display("test registers done");

        // per-entry purge verdicts, back to back
        for (i = 0; i <= 120; i++) begin
            @(posedge ref_clk);
            lo = 4'($random(seed));
            le = sgcr_entry_t'({$random(seed)} % 2 ? 6'h20 : 6'h00);
            le.ports = 4'h1 << ($unsigned($random(seed)) % 4);
            fe = 6'($random(seed));
            if (i % 3 == 0) fe.ports = le.ports;
            learn_off <= lo;
            learned_entry <= le;
            fixed_entry <= fe;
            #1;
            if (i > 0) begin
                chk1(learned_purge_hit, el);
                chk1(fixed_purge_hit, ef);
            end
            el = le.valid & |(le.ports & lo);
            ef = fe.valid & fe.unicast & $onehot(fe.ports) & |(fe.ports & lo);
        end
        $display("test purge_match done");

        // frame filter in both modes
        for (n = 0; n < 2; n++) begin
            reg_write(SGCR_ADDR_GC0, n[0] ? 8'h02 : 8'h00);
            repeat (3) @(posedge ref_clk);
            for (i = 0; i <= 60; i++) begin
                @(posedge ref_clk);
                fr = 66'({$random(seed), $random(seed), $random(seed)});
                if (i % 4 == 1) fr.type_len = SGCR_PAUSE_TYPE;
                if (i % 4 == 2) fr.dest = SGCR_TEST_DA;
                rx_frame <= fr;
                #1;
                if (i > 0) chk1(frame_drop, ed);
                ed = fr.valid & (n[0] ? (fr.type_len == 16'h8808 ||
                                         fr.dest == 48'h0180C2000001) : fr.flow_ctrl);
            end
        end
        $display("test frame_filter done");

        // link loss ignored while aging on link change is off
        reg_write(SGCR_ADDR_GC0, 8'h00);
        link_up_pin <= 4'hE;
        no_age(12);
        chk1(seen, 1'b0);
        link_up_pin <= 4'hF;
        no_age(8);
        // link loss with bit 0 set: fast cycle, then normal period
        reg_write(SGCR_ADDR_GC0, 8'h01);
        repeat (3) @(posedge ref_clk);
        link_up_pin <= 4'hB;
        n = 0;
        while (age_all_now !== 1'b1 && n < 10) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk1(age_all_now, 1'b1);
        chk1(fast_age_active, 1'b1);
        n = 0;
        while (fast_age_active === 1'b1 && n < 200) begin
            n++;
            @(posedge ref_clk);
            #1;
        end
        // the fast window closes one cycle short of its count, safely under the limit
        chk8(8'(n), 8'(FAST - 1));
        seen = 1'b0;
        for (i = 0; i < NORM + 3 && !seen; i++) begin
            @(posedge ref_clk);
            #1 seen = age_tick;
        end
        chk1(seen, 1'b1);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (age_tick !== 1'b1 && n < 200);
        chk8(8'(n), 8'(NORM));
        link_up_pin <= 4'hF;
        no_age(8);
        chk1(seen, 1'b0);
        $display("test link_aging done");
        close_out();
    end
endmodule
